// ### verilog/fppc_params.svh
/*
  Constants of the flash page program control: register offsets, field
  positions, reset values and timing counts.
  Assumes inclusion by bare name from the top module and the testbench.
*/
`ifndef FPPC_PARAMS_SVH
`define FPPC_PARAMS_SVH

// Register byte offsets
`define FPPC_OFS_CTRL        8'h00
`define FPPC_OFS_STAT        8'h04
`define FPPC_OFS_IRQ_STATUS  8'h08
`define FPPC_OFS_IRQ_ENABLE  8'h0C
`define FPPC_OFS_IRQ_CLEAR   8'h10

// Field positions
`define FPPC_CTRL_ENABLE_BIT 0
`define FPPC_STAT_BUSY_BIT   0
`define FPPC_STAT_CODE_LSB   1
`define FPPC_STAT_CODE_MSB   2
`define FPPC_IRQ_OK_BIT      0
`define FPPC_IRQ_ERR_BIT     1
`define FPPC_IRQ_LOCK_BIT    2
`define FPPC_IRQ_W           3

// Reset values
`define FPPC_CTRL_RESET      1'h1
`define FPPC_IRQ_EN_RESET    3'h0

// Timing
`define FPPC_CLK_MHZ         10
`define FPPC_PROG_TIME_US    6800
`define FPPC_PROG_CYCLES     (`FPPC_PROG_TIME_US * `FPPC_CLK_MHZ)

// Array geometry defaults
`define FPPC_ADDR_W          8
`define FPPC_WCOUNT_W        16
`define FPPC_WR_THRESH       16'h03E8

`endif

// ### verilog/fppc_pkg.sv
/*
  Types of the flash page program control: controller states and the
  two-bit outcome code.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package fppc_pkg;

  typedef enum logic [3:0] {
    FPPC_IDLE  = 4'h1,
    FPPC_WRITE = 4'h2,
    FPPC_ABORT = 4'h4,
    FPPC_DONE  = 4'h8
  } fppc_state_t;

  typedef enum logic [1:0] {
    FPPC_ST_OK     = 2'h0,
    FPPC_ST_REFUSE = 2'h1,
    FPPC_ST_ECC    = 2'h2,
    FPPC_ST_WCOUNT = 2'h3
  } fppc_status_t;

endpackage

`default_nettype wire

// ### verilog/fppc_top.sv
/*
  Flash page program control: takes program and page erase requests from
  fabric logic, checks address, buffer state and page locks, drives the
  array write, holds busy and reports a two-bit outcome. APB register port.
  Assumes a single 10 MHz clock, synchronous inputs, and page buffer and
  array logic outside that report buffer state and ECC results.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fppc_params.svh"

// How it works
// - A program request writes the page buffer into the flash array.
// - Programming, erase included, takes 6.8 ms per page before completion.
// - Busy stays high for the whole array write.
// - Address differing from the buffered page aborts a program request without redirect with an error code; erase is not checked.
// - Redirect option writes the buffer to the addressed page unless locked or in page-loss protection.
// - Lock option with a program request locks the addressed page.
// - Locked pages are refused by any later program or erase.
// - Code 01 or a lock request means page untouched; any other code means page modified.
// - Programming a locked page reports 01.
// - In page-loss protection, programming another page reports 01.
// - Redirect onto a locked page reports 01.
// - Write count above threshold reports 11.
// - Uncorrectable ECC error in the programmed page reports 10.
// - Other page, no redirect, modified buffer reports 01.
// - Programming the buffered page while unmodified is an error.
// - Redirect option is sampled only with program or page erase requests.
module fppc_top
#(
  parameter int ADDR_W      = `FPPC_ADDR_W,
  parameter int WCOUNT_W    = `FPPC_WCOUNT_W,
  parameter int PROG_CYCLES = `FPPC_PROG_CYCLES,
  parameter logic [`FPPC_WCOUNT_W-1:0] WR_THRESH = `FPPC_WR_THRESH
)
(
  // Clock and reset
  input  wire logic                       REF_CLK,
  input  wire logic                       RST_N,
  // APB slave
  input  wire logic                       PSEL,
  input  wire logic                       PENABLE,
  input  wire logic                       PWRITE,
  input  wire logic [7:0]                 PADDR,
  input  wire logic [31:0]                PWDATA,
  output logic                            PREADY,
  output logic [31:0]                     PRDATA,
  output logic                            PSLVERR,
  // Fabric request side
  input  wire logic                       PROGRAM_REQ,
  input  wire logic                       PAGE_ERASE_REQ,
  input  wire logic                       REDIRECT_PAGE_OPTION,
  input  wire logic                       PAGE_LOCK_OPTION,
  input  wire logic [ADDR_W-1:0]          ADDR,
  output logic                            BUSY,
  output fppc_pkg::fppc_status_t          STATUS,
  // Page buffer state
  input  wire logic [ADDR_W-1:0]          BUF_ADDR,
  input  wire logic                       BUF_MODIFIED,
  input  wire logic                       BUF_LOSS_PROTECT,
  // Flash array side
  input  wire logic                       ARRAY_ECC_ERR,
  output logic                            ARRAY_PROGRAM,
  output logic                            ARRAY_ERASE,
  output logic [ADDR_W-1:0]               ARRAY_ADDR,
  // Interrupt
  output logic                            IRQ
);
  import fppc_pkg::*;

  localparam int NUM_PAGES = 1 << ADDR_W;

  fppc_state_t            state;
  fppc_state_t            next_state;
  logic [31:0]            cnt;
  logic                   prog_q;
  logic                   erase_q;
  logic                   op_erase;
  logic                   op_lock;
  logic [ADDR_W-1:0]      op_addr;
  logic                   ctrl_enable;
  logic [`FPPC_IRQ_W-1:0] irq_status;
  logic [`FPPC_IRQ_W-1:0] irq_enable;
  logic [NUM_PAGES-1:0]   lock_bits;
  logic [WCOUNT_W-1:0]    wcount [NUM_PAGES];

  // Request decode
  wire prog_start  = PROGRAM_REQ & ~prog_q & ctrl_enable & (state == FPPC_IDLE);
  wire erase_start = PAGE_ERASE_REQ & ~erase_q & ctrl_enable & (state == FPPC_IDLE)
                     & ~PROGRAM_REQ;
  wire any_start   = prog_start | erase_start;
  wire redirect    = REDIRECT_PAGE_OPTION & (PROGRAM_REQ | PAGE_ERASE_REQ);
  wire addr_match  = (ADDR == BUF_ADDR);
  wire page_locked = lock_bits[ADDR];

  // Refusal checks
  wire refuse_lock = page_locked;
  wire refuse_plp  = prog_start & BUF_LOSS_PROTECT & ~addr_match;
  wire refuse_mism = prog_start & ~addr_match & ~redirect;
  wire refuse_unm  = prog_start & addr_match & ~BUF_MODIFIED
                     & ~PAGE_LOCK_OPTION;
  wire refuse      = refuse_lock | refuse_plp | refuse_mism | refuse_unm;

  // Outcome at end of write
  wire [WCOUNT_W-1:0] next_wcount = wcount[op_addr] + 1'b1;
  wire                over_thresh = ~op_erase & ~op_lock
                                    & (next_wcount > WR_THRESH);
  wire write_done  = (state == FPPC_WRITE) & (cnt == 32'(PROG_CYCLES - 1));

  fppc_status_t next_status;
  assign next_status = ARRAY_ECC_ERR ? FPPC_ST_ECC
                     : over_thresh   ? FPPC_ST_WCOUNT
                     :                 FPPC_ST_OK;

  // APB decode
  wire apb_setup = PSEL & ~PENABLE;
  wire apb_wr    = PSEL & PENABLE & PREADY & PWRITE;
  wire hit_ctrl  = (PADDR == `FPPC_OFS_CTRL);
  wire hit_stat  = (PADDR == `FPPC_OFS_STAT);
  wire hit_ists  = (PADDR == `FPPC_OFS_IRQ_STATUS);
  wire hit_ien   = (PADDR == `FPPC_OFS_IRQ_ENABLE);
  wire hit_iclr  = (PADDR == `FPPC_OFS_IRQ_CLEAR);
  wire hit_any   = hit_ctrl | hit_stat | hit_ists | hit_ien | hit_iclr;

  wire [31:0] rd_ctrl = {31'h0, ctrl_enable};
  wire [31:0] rd_stat = {29'h0, STATUS, BUSY};
  wire [31:0] rd_ists = {29'h0, irq_status};
  wire [31:0] rd_ien  = {29'h0, irq_enable};
  wire [31:0] next_prdata = (PWRITE | ~apb_setup) ? 32'h0
                          : hit_ctrl ? rd_ctrl
                          : hit_stat ? rd_stat
                          : hit_ists ? rd_ists
                          : hit_ien  ? rd_ien
                          :            32'h0;

  // Interrupt events
  wire ev_ok   = (state == FPPC_WRITE) & write_done & (next_status == FPPC_ST_OK);
  wire ev_err  = ((state == FPPC_WRITE) & write_done & (next_status != FPPC_ST_OK))
                 | (state == FPPC_ABORT);
  wire ev_lock = (state == FPPC_WRITE) & write_done & op_lock;
  wire [`FPPC_IRQ_W-1:0] irq_events = {ev_lock, ev_err, ev_ok};
  wire [`FPPC_IRQ_W-1:0] irq_clr    = (apb_wr & hit_iclr) ? PWDATA[`FPPC_IRQ_W-1:0]
                                                            : {`FPPC_IRQ_W{1'b0}};
  wire [`FPPC_IRQ_W-1:0] next_irq_status = (irq_status & ~irq_clr) | irq_events;

  // Next state
  always_comb
  begin
    next_state = state;
    case (state)
      FPPC_IDLE:
        if (any_start)
          next_state = refuse ? FPPC_ABORT : FPPC_WRITE;
      FPPC_WRITE:
        if (write_done)
          next_state = FPPC_DONE;
      FPPC_ABORT:
        next_state = FPPC_DONE;
      FPPC_DONE:
        next_state = FPPC_IDLE;
      default:
        next_state = FPPC_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state   <= FPPC_IDLE;
      cnt     <= 32'h0;
      prog_q  <= 1'b0;
      erase_q <= 1'b0;
    end
    else
    begin
      state   <= next_state;
      cnt     <= (state == FPPC_WRITE) ? cnt + 32'h1 : 32'h0;
      prog_q  <= PROGRAM_REQ;
      erase_q <= PAGE_ERASE_REQ;
    end
  end

  // Operation capture and user outputs
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      op_erase      <= 1'b0;
      op_lock       <= 1'b0;
      op_addr       <= '0;
      BUSY          <= 1'b0;
      STATUS        <= FPPC_ST_OK;
      ARRAY_PROGRAM <= 1'b0;
      ARRAY_ERASE   <= 1'b0;
      ARRAY_ADDR    <= '0;
    end
    else
    begin
      ARRAY_PROGRAM <= prog_start & ~refuse & ~PAGE_LOCK_OPTION;
      ARRAY_ERASE   <= erase_start & ~refuse;
      if (any_start)
      begin
        op_erase   <= erase_start;
        op_lock    <= prog_start & PAGE_LOCK_OPTION;
        op_addr    <= ADDR;
        ARRAY_ADDR <= ADDR;
        BUSY       <= 1'b1;
      end
      else if (state == FPPC_ABORT)
      begin
        BUSY   <= 1'b0;
        STATUS <= FPPC_ST_REFUSE;
      end
      else if (write_done)
      begin
        BUSY   <= 1'b0;
        STATUS <= next_status;
      end
    end
  end

  // Lock bits and write counts
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      lock_bits <= '0;
      for (int i = 0; i < NUM_PAGES; i++)
        wcount[i] <= '0;
    end
    else if (write_done)
    begin
      if (op_lock)
        lock_bits[op_addr] <= 1'b1;
      else if (op_erase)
        wcount[op_addr] <= '0;
      else
        wcount[op_addr] <= next_wcount;
    end
  end

  // APB registers
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      PREADY      <= 1'b0;
      PRDATA      <= 32'h0;
      PSLVERR     <= 1'b0;
      ctrl_enable <= `FPPC_CTRL_RESET;
      irq_enable  <= `FPPC_IRQ_EN_RESET;
      irq_status  <= '0;
      IRQ         <= 1'b0;
    end
    else
    begin
      PREADY     <= apb_setup;
      PRDATA     <= next_prdata;
      PSLVERR    <= apb_setup & ~hit_any;
      irq_status <= next_irq_status;
      IRQ        <= |(next_irq_status & irq_enable);
      if (apb_wr & hit_ctrl)
        ctrl_enable <= PWDATA[`FPPC_CTRL_ENABLE_BIT];
      if (apb_wr & hit_ien)
        irq_enable <= PWDATA[`FPPC_IRQ_W-1:0];
    end
  end

endmodule

`default_nettype wire

// ### sim/fppc_checker.sv
/* Checker of the page program control, bound to the top module.
   Assumes the bind hands on ADDR_W and PROG_CYCLES. */
`timescale 1ns/1ps
`default_nettype none
module fppc_checker
#(
  parameter int ADDR_W      = 8,
  parameter int PROG_CYCLES = 20
)
(
  // Clock and reset
  input wire logic                   REF_CLK,
  input wire logic                   RST_N,
  // Requests and outcome
  input wire logic                   PROGRAM_REQ,
  input wire logic                   PAGE_ERASE_REQ,
  input wire logic [ADDR_W-1:0]      ADDR,
  input wire logic                   BUSY,
  input wire fppc_pkg::fppc_status_t STATUS,
  // Array side
  input wire logic                   ARRAY_PROGRAM,
  input wire logic                   ARRAY_ERASE,
  input wire logic [ADDR_W-1:0]      ARRAY_ADDR
);
  import fppc_pkg::*;
  int   cnt;
  logic seen;
  // Busy length and array write seen
  always_ff @(posedge REF_CLK or negedge RST_N)
    if (!RST_N)
    begin
      cnt  <= 0;
      seen <= 1'b0;
    end
    else
    begin
      cnt  <= BUSY ? cnt + 1 : 0;
      seen <= BUSY & (seen | ARRAY_PROGRAM);
    end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  start_busy_a: assert property (($rose(PROGRAM_REQ) || $rose(PAGE_ERASE_REQ)) && !BUSY
    |=> BUSY) else $error("busy missing after request");
  write_busy_a: assert property (ARRAY_PROGRAM |-> BUSY ##1 (BUSY && !ARRAY_PROGRAM))
    else $error("array write outside busy");
  busy_len_a: assert property ($fell(BUSY) |-> cnt == 1 || cnt == PROG_CYCLES)
    else $error("busy length wrong");
  refuse_clean_a: assert property ($fell(BUSY) && STATUS == FPPC_ST_REFUSE |-> !seen)
    else $error("refused page was written");
  written_code_a: assert property ($fell(BUSY) && seen |-> STATUS != FPPC_ST_REFUSE)
    else $error("written page reported refused");
  status_hold_a: assert property (!BUSY && !$past(BUSY) |-> $stable(STATUS))
    else $error("status changed while idle");
  page_taken_a: assert property (ARRAY_PROGRAM |-> ARRAY_ADDR == $past(ADDR))
    else $error("array page differs from request");
  erase_pulse_a: assert property ($rose(ARRAY_ERASE) |-> BUSY ##1 !ARRAY_ERASE)
    else $error("erase pulse wrong");
  cover property ($fell(BUSY) && STATUS == FPPC_ST_REFUSE);
  cover property ($fell(BUSY) && seen);
  cover property ($rose(ARRAY_ERASE));
endmodule
bind fppc_top fppc_checker #(.ADDR_W(ADDR_W), .PROG_CYCLES(PROG_CYCLES)) chk_u (.REF_CLK,
  .RST_N, .PROGRAM_REQ, .PAGE_ERASE_REQ, .ADDR, .BUSY, .STATUS, .ARRAY_PROGRAM,
  .ARRAY_ERASE, .ARRAY_ADDR);
`default_nettype wire

// ### sim/fppc_fabric.sv
/* Fabric requester model: one program or erase request at a time.
   Assumes BUSY from the control block. */
`timescale 1ns/1ps
`default_nettype none
module fppc_fabric
(
  // Clock and answer
  input  wire logic  clk,
  input  wire logic  busy,
  // Request pins
  output logic       prog,
  output logic       erase,
  output logic       redir,
  output logic       lock,
  output logic [7:0] addr
);
  initial {prog, erase, redir, lock, addr} = '0;
  // Options flip once released
  task automatic req(input logic e, input logic r, input logic l, input logic [7:0] a);
    @(posedge clk);
    while (busy !== 1'b0) @(posedge clk);
    {erase, prog, redir, lock, addr} <= {e, !e, r, l, a};
    @(posedge clk);
    {erase, prog, redir, lock} <= {1'b0, 1'b0, !r, !l};
  endtask
endmodule
`default_nettype wire

// ### sim/testbench.sv
/* Testbench of the page program control: registers and outcomes against a model.
   Assumes the fabric model raises the requests. */
`timescale 1ns/1ps
`default_nettype none
`include "fppc_params.svh"
module testbench;
  import fppc_pkg::*;
  localparam int PC = 20;
  localparam int TH = 3;
  logic         clk, rst_n, psel, pen, pwr, pready, perr, pslverr, irq, busy;
  logic         bmod, blp, ecc, fprog, ferase, fredir, flock, aprog, aerase;
  logic [7:0]   paddr, baddr, faddr, aaddr;
  logic [31:0]  pwdata, prdata, q;
  fppc_status_t st;
  int           errors, n_checks, xl, wc[256];
  bit           lk[256];
  logic [21:0]  tbl[15] = '{22'h020101, 22'h020201, 22'h120301, 22'h080505, 22'h120501,
    22'h020505, 22'h220505, 22'h160601, 22'h000707, 22'h030808, 22'h220101,
    22'h020909, 22'h020909, 22'h020909, 22'h020909};
  fppc_top #(.PROG_CYCLES(PC), .WR_THRESH(16'h0003)) dut_u (.REF_CLK(clk), .RST_N(rst_n),
    .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
    .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr), .PROGRAM_REQ(fprog),
    .PAGE_ERASE_REQ(ferase), .REDIRECT_PAGE_OPTION(fredir), .PAGE_LOCK_OPTION(flock),
    .ADDR(faddr), .BUSY(busy), .STATUS(st), .BUF_ADDR(baddr), .BUF_MODIFIED(bmod),
    .BUF_LOSS_PROTECT(blp), .ARRAY_ECC_ERR(ecc), .ARRAY_PROGRAM(aprog),
    .ARRAY_ERASE(aerase), .ARRAY_ADDR(aaddr), .IRQ(irq));
  fppc_fabric fab_u (.clk(clk), .busy(busy), .prog(fprog), .erase(ferase),
    .redir(fredir), .lock(flock), .addr(faddr));
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected %s expected %0h seen %0h", s, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk);
    {psel, pen, pwr, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++t < 50);
    q = prdata;
    perr = pslverr;
    {psel, pen} <= 2'b00;
  endtask
  task automatic op(input logic [21:0] v);
    logic [7:0] a, b;
    int         n, w;
    a = v[15:8];
    b = v[7:0];
    baddr <= b;
    {blp, bmod, ecc} <= v[18:16];
    xl = (lk[a] || (!v[21] && ((v[18] && a != b) || (a != b && !v[20])
      || (a == b && !v[17] && !v[19]))));
    if (xl == 0 && v[21]) wc[a] = 0;
    if (xl == 0 && v[19]) lk[a] = 1;
    w = (xl == 0 && !v[21] && !v[19]);
    wc[a] += w;
    if (w) xl = v[16] ? 2 : (wc[a] > TH ? 3 : 0);
    fab_u.req(v[21], v[20], v[19], a);
    #1;
    for (n = 0; busy === 1'b1 && n < 99; n++) @(posedge clk) #1;
    chk("busy cycles", xl == 1 ? 1 : PC, n);
    chk("status", xl, st);
    if (xl != 1) chk("array page", a, aaddr);
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    end_of_test();
  end
  initial
  begin
    {rst_n, psel, pen, pwr, paddr, pwdata, baddr, bmod, blp, ecc} = '0;
    void'($urandom(32'h4312));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, `FPPC_OFS_CTRL, 32'h0);
    chk("ctrl", 32'h1, q);
    apb(1'b1, `FPPC_OFS_CTRL, 32'h0);
    apb(1'b0, `FPPC_OFS_CTRL, 32'h0);
    chk("ctrl off", 32'h0, q);
    apb(1'b1, `FPPC_OFS_CTRL, 32'h1);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h1, perr);
    apb(1'b1, `FPPC_OFS_IRQ_ENABLE, 32'h7);
    foreach (tbl[i]) op(tbl[i]);
    repeat (16) op({1'b0, 1'($urandom), 1'b0, 3'($urandom), 8'($urandom % 4),
      8'($urandom % 4)});
    chk("irq", 32'h1, irq);
    apb(1'b0, `FPPC_OFS_IRQ_STATUS, 32'h0);
    chk("irq status", 32'h7, q);
    apb(1'b1, `FPPC_OFS_IRQ_CLEAR, 32'h7);
    apb(1'b0, `FPPC_OFS_IRQ_STATUS, 32'h0);
    chk("irq cleared", 32'h0, q);
    apb(1'b1, `FPPC_OFS_IRQ_ENABLE, 32'h0);
    op(22'h020202);
    apb(1'b0, `FPPC_OFS_IRQ_STATUS, 32'h0);
    chk("irq event", xl == 0 ? 32'h1 : 32'h2, q);
    chk("irq masked", 32'h0, irq);
    end_of_test();
  end
endmodule
`default_nettype wire
